// ---- hdl/dcrm_core.sv ----
// core register model: pc, working registers, shadows, status, exceptions
//
// Overview of operation
// - fetch 24-bit words; 23-bit pc with bit 0 forced to zero
// - pc top bit cleared in sequencing, used only by special jumps
// - loop and repeat state survives interruption at any point
// - sixteen 16-bit working registers; the last is the stack pointer
// - data space split into x and y at a fixed boundary
// - upper 32K data maps into program page; extra cycle, low 16 bits
// - table read reaches all 24 instruction bits
// - x generator bit-reverses destination effective addresses on request
// - per cycle: one data read, register read, data write, fetch
// - barrel shift up to 15 right or 16 left in one cycle
// - multiplier forms the product of two working registers, no accumulate
// - single-stage prefetch one cycle ahead; most ops take one cycle
// - 62 vectors: 8 trap slots, 4 of them reserved, and 54 interrupts
// - irq priority 1..7 with natural order ties; traps fixed 8..15
// - shadow push/pop moves w0..w3 and dc, n, ov, z, c only
// - loop start pushes loop registers to shadows; loop end pops them
// - shadows are not accessible; only transfer events change them
// - byte writes to a working register touch only its low byte
// - stack pointer moves on exception, call, return; bit 0 zero
// - reset loads stack pointer with 0x0800; software may rewrite
// - status low byte alu flags, priority, repeat; high dsp, loop, dc
// - exception entry stacks status low byte with pc top byte
`timescale 1ns/100ps
`default_nettype none
module dcrm_core #(
  parameter int unsigned TRAPS_USED = 4
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  // program fetch
  input  wire logic [23:0]           insn_i,
  output logic      [22:0]           fetch_addr_o,
  output logic      [23:0]           prefetch_o,
  // register write and read ports
  input  wire dcrm_pkg::dcrm_wr_t    wr_i,
  input  wire logic [3:0]            rd_idx_i,
  output logic      [15:0]           rd_data_o,
  input  wire logic [3:0]            mul_a_idx_i,
  input  wire logic [3:0]            mul_b_idx_i,
  output logic      [31:0]           mul_o,
  // sequencing controls
  input  wire logic                  stall_i,
  input  wire logic                  jump_i,
  input  wire logic                  jump_long_i,
  input  wire logic [22:0]           jump_addr_i,
  input  wire logic                  call_i,
  input  wire logic                  ret_i,
  input  wire logic [15:0]           ret_word_i,
  // status and page registers
  input  wire logic                  sr_we_i,
  input  wire logic [15:0]           sr_wdata_i,
  input  wire logic                  psv_we_i,
  input  wire logic [7:0]            psv_wdata_i,
  output logic      [15:0]           sr_o,
  output logic      [7:0]            psv_page_o,
  // shadow and loop events
  input  wire logic                  push_s_i,
  input  wire logic                  pop_s_i,
  input  wire logic                  loop_start_i,
  input  wire logic                  loop_end_i,
  input  wire dcrm_pkg::dcrm_loop_t  loop_i,
  output dcrm_pkg::dcrm_loop_t       loop_o,
  // data access and address generation
  input  wire logic                  dread_i,
  input  wire logic [15:0]           daddr_i,
  input  wire logic                  bitrev_i,
  input  wire logic [15:0]           dest_ea_i,
  output logic      [15:0]           dest_ea_o,
  output logic                       is_y_space_o,
  output logic                       psv_busy_o,
  output logic      [22:0]           psv_addr_o,
  output logic      [15:0]           psv_data_o,
  input  wire logic [22:0]           tbl_addr_i,
  output logic      [23:0]           tbl_data_o,
  // barrel shifter
  input  wire logic [15:0]           sh_src_i,
  input  wire logic signed [5:0]     sh_amt_i,
  output logic      [31:0]           sh_o,
  // exceptions
  input  wire logic [53:0]           irq_req_i,
  input  wire logic [161:0]          irq_pri_i,
  input  wire logic [7:0]            trap_req_i,
  output logic                       exc_take_o,
  output logic      [5:0]            exc_vec_o,
  output logic      [15:0]           exc_stack_word_o
);
  import dcrm_pkg::*;

  typedef struct packed {
    dcrm_state_t st;
    logic [22:0] pc;
    logic [23:0] pref;
    logic [15:0] sr;
    logic [7:0]  psv;
    logic [255:0] w;
    logic [63:0]  w_sh;
    logic [15:0]  sr_sh;
    dcrm_loop_t   lp;
    dcrm_loop_t   lp_sh;
    logic [15:0]  dea;
    logic [22:0]  paddr;
    logic         exc;
    logic [5:0]   vec;
    logic [15:0]  stk;
  } dcrm_regs_t;

  dcrm_regs_t r, next_r;

  function automatic logic [15:0] bit_rev(input logic [15:0] a);
    for (int i = 0; i < 16; i++) bit_rev[i] = a[15-i];
  endfunction : bit_rev

  function automatic logic [15:0] wreg(input logic [255:0] w,
                                       input logic [3:0] i);
    wreg = w[i*16 +: 16];
  endfunction : wreg

  function automatic logic [2:0] irq_level(input logic [161:0] p,
                                           input int q);
    irq_level = p[q*3 +: 3];
  endfunction : irq_level

  // traps above the honoured count are reserved and never win
  localparam logic [7:0] TRAP_MASK = 8'((16'h0001 << TRAPS_USED) - 16'h0001);

  // exception arbitration, combinational
  logic       arb_hit;
  logic [5:0] arb_vec;
  logic [3:0] arb_pri;
  always_comb begin
    arb_hit = 1'b0;
    arb_vec = 6'h00;
    arb_pri = 4'h0;
    // traps first: higher index is higher fixed priority
    for (int t = 0; t < TRAP_N; t++) begin
      if (trap_req_i[t] && t < TRAPS_USED
          && (TRAP_PRI_BASE + 4'(t)) > arb_pri) begin
        arb_hit = 1'b1;
        arb_vec = 6'(t);
        arb_pri = TRAP_PRI_BASE + 4'(t);
      end
    end
    // lower index wins ties; strict compare keeps the natural order
    for (int q = 0; q < IRQ_N; q++) begin
      if (irq_req_i[q] && {1'b0, irq_level(irq_pri_i, q)} > arb_pri
          && irq_level(irq_pri_i, q) > r.sr[SR_IPL +: 3]) begin
        arb_hit = 1'b1;
        arb_vec = 6'(TRAP_N + q);
        arb_pri = {1'b0, irq_level(irq_pri_i, q)};
      end
    end
  end

  logic psv_hit;
  assign psv_hit = dread_i && daddr_i[15];

  always_comb begin
    next_r     = r;
    next_r.exc = 1'b0;
    unique case (r.st)
      DCRM_EXEC: begin
        if (arb_hit && !stall_i) begin
          // stack sr low byte with the pc high byte
          next_r.stk = {r.sr[7:0], 1'b0, r.pc[22:16]};
          next_r.exc = 1'b1;
          next_r.vec = arb_vec;
          next_r.pc  = {16'h0000, arb_vec, 1'b0};
          // loop registers are left intact so the loop resumes
          next_r.w[SP_INDEX*16 +: 16] = wreg(r.w, SP_INDEX) + 16'h0004;
          next_r.st  = DCRM_EXC;
        end else if (psv_hit) begin
          next_r.paddr = {r.psv, daddr_i[14:1], 1'b0};
          next_r.st    = DCRM_PSV2; // one extra cycle
        end else if (!stall_i) begin
          next_r.pref = insn_i; // prefetch one ahead
          if (jump_i || call_i)
            next_r.pc = {jump_long_i ? jump_addr_i[22] : 1'b0,
                         jump_addr_i[21:1], 1'b0};
          else if (ret_i)
            next_r.pc = {7'h00, ret_word_i[15:1], 1'b0};
          else
            next_r.pc = {1'b0, r.pc[21:0] + 22'h000002};
          if (call_i)
            next_r.w[SP_INDEX*16 +: 16] = wreg(r.w, SP_INDEX)
                                          + 16'h0004;
          if (ret_i)
            next_r.w[SP_INDEX*16 +: 16] = wreg(r.w, SP_INDEX)
                                          - 16'h0004;
        end
      end
      DCRM_PSV2: next_r.st = DCRM_EXEC;
      DCRM_EXC:  next_r.st = DCRM_EXEC;
      default:   next_r.st = DCRM_EXEC;
    endcase

    if (wr_i.we) begin
      if (wr_i.byte_op)
        next_r.w[wr_i.idx*16 +: 8] = wr_i.data[7:0];
      else
        next_r.w[wr_i.idx*16 +: 16] = wr_i.data;
    end
    next_r.w[SP_INDEX*16] = 1'b0;

    if (sr_we_i) next_r.sr = sr_wdata_i;
    if (psv_we_i) next_r.psv = psv_wdata_i;

    // shadows change only on these events
    if (push_s_i) begin
      next_r.w_sh  = r.w[63:0];
      next_r.sr_sh = r.sr & SHADOW_SR_MASK;
    end else if (pop_s_i) begin
      next_r.w[63:0] = r.w_sh;
      next_r.sr = (r.sr & ~SHADOW_SR_MASK) | r.sr_sh;
    end
    if (loop_start_i) begin
      next_r.lp_sh = r.lp;
      next_r.lp    = loop_i;
      next_r.sr[SR_DA] = 1'b1;
    end else if (loop_end_i) begin
      next_r.lp = r.lp_sh;
      next_r.sr[SR_DA] = 1'b0;
    end

    // bit reversal on destination addresses only
    next_r.dea = bitrev_i ? bit_rev(dest_ea_i) : dest_ea_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r    <= '0;
      r.pc <= PC_RESET;
      r.sr <= SR_RESET;
      r.st <= DCRM_EXEC;
      r.w[SP_INDEX*16 +: 16] <= SP_RESET;
    end else begin
      r <= next_r;
    end
  end

  // barrel shifter: negative amount shifts right
  always_comb begin
    if (sh_amt_i < 0 && sh_amt_i >= -6'sd15)
      sh_o = {16'h0000, sh_src_i >> 4'(-sh_amt_i)};
    else if (sh_amt_i >= 0 && sh_amt_i <= 6'sd16)
      sh_o = {16'h0000, sh_src_i} << 5'(sh_amt_i);
    else
      sh_o = 32'h00000000;
  end

  // the window read borrows the fetch port for its extra cycle
  assign fetch_addr_o     = (r.st == DCRM_PSV2) ? r.paddr
                            : r.pc;
  assign prefetch_o       = r.pref;
  assign rd_data_o        = wreg(r.w, rd_idx_i);
  assign mul_o            = wreg(r.w, mul_a_idx_i)
                            * wreg(r.w, mul_b_idx_i);
  assign sr_o             = r.sr;
  assign psv_page_o       = r.psv;
  assign loop_o           = r.lp;
  assign dest_ea_o        = r.dea;
  assign is_y_space_o     = (daddr_i >= XY_BOUNDARY)
                            && !daddr_i[15];
  assign psv_busy_o       = (r.st == DCRM_PSV2);
  assign psv_addr_o       = r.paddr;
  assign psv_data_o       = insn_i[15:0];
  assign tbl_data_o       = insn_i;
  assign exc_take_o       = r.exc;
  assign exc_vec_o        = r.vec;
  assign exc_stack_word_o = r.stk;

  // checks share one clock and reset
  default clocking cb_core @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_pc_lsb_zero: assert property (r.pc[0] == 1'b0)
    else $error("pc bit 0 set");
  a_sp_lsb_zero: assert property (r.w[SP_INDEX*16] == 1'b0)
    else $error("sp bit 0 set");
  a_psv_extra_cycle: assert property (
    (r.st == DCRM_EXEC && psv_hit && !(arb_hit && !stall_i))
    |=> psv_busy_o ##1 !psv_busy_o)
    else $error("psv timing");
  a_psv_page_used: assert property (
    psv_busy_o |-> psv_addr_o[22:15] == $past(r.psv))
    else $error("psv page");
  a_word_write: assert property (
    (wr_i.we && !wr_i.byte_op && wr_i.idx != SP_INDEX && !pop_s_i)
    |=> r.w[$past(wr_i.idx)*16 +: 16] == $past(wr_i.data))
    else $error("word write lost");
  a_byte_keeps_high: assert property (
    (wr_i.we && wr_i.byte_op && wr_i.idx != SP_INDEX && !pop_s_i)
    |=> r.w[$past(wr_i.idx)*16+8 +: 8] == $past(r.w[wr_i.idx*16+8 +: 8]))
    else $error("byte write hit high");
  a_exc_stack_word: assert property (
    exc_take_o |-> exc_stack_word_o[15:8] == $past(r.sr[7:0])
      && exc_stack_word_o[6:0] == $past(r.pc[22:16]))
    else $error("bad stacked word");
  a_exc_vector: assert property (
    exc_take_o |-> exc_vec_o < 6'(EXC_VEC_N)
      && r.pc == {16'h0000, exc_vec_o, 1'b0})
    else $error("bad vector");
  a_loop_restore: assert property (
    (loop_end_i && !loop_start_i) |=> loop_o == $past(r.lp_sh))
    else $error("loop not restored");
  a_loop_push: assert property (
    loop_start_i |=> r.lp_sh == $past(r.lp))
    else $error("loop not pushed");
  a_loop_flag_set: assert property (
    loop_start_i |=> r.sr[SR_DA])
    else $error("loop flag not set");
  a_loop_flag_clr: assert property (
    (loop_end_i && !loop_start_i) |=> !r.sr[SR_DA])
    else $error("loop flag not cleared");
  a_shadow_stable: assert property (
    !push_s_i |=> $stable(r.w_sh) && $stable(r.sr_sh))
    else $error("shadow changed");
  a_pop_restores: assert property (
    (pop_s_i && !push_s_i && !wr_i.we) |=> r.w[63:0] == $past(r.w_sh))
    else $error("shadow not restored");
  a_pc_top_clear: assert property (
    (r.st == DCRM_EXEC && !stall_i && !arb_hit && !psv_hit && !jump_i
     && !call_i && !ret_i) |=> !r.pc[22])
    else $error("pc top");
  a_stall_holds_pc: assert property (
    stall_i |=> r.pc == $past(r.pc))
    else $error("pc moved in stall");
  a_prefetch_word: assert property (
    (r.st == DCRM_EXEC && !stall_i && !arb_hit && !psv_hit)
    |=> prefetch_o == $past(insn_i))
    else $error("prefetch word");
  a_dest_plain: assert property (
    !bitrev_i |=> dest_ea_o == $past(dest_ea_i))
    else $error("plain ea changed");
  a_call_sp_step: assert property (
    (r.st == DCRM_EXEC && !stall_i && !arb_hit && !psv_hit && call_i
     && !ret_i && !(wr_i.we && wr_i.idx == SP_INDEX))
    |=> wreg(r.w, SP_INDEX) == $past(wreg(r.w, SP_INDEX)) + 16'h0004)
    else $error("call sp step");
  a_ret_sp_step: assert property (
    (r.st == DCRM_EXEC && !stall_i && !arb_hit && !psv_hit && ret_i
     && !call_i && !(wr_i.we && wr_i.idx == SP_INDEX))
    |=> wreg(r.w, SP_INDEX) == $past(wreg(r.w, SP_INDEX)) - 16'h0004)
    else $error("return sp step");
  a_exc_priority: assert property (
    (arb_hit && arb_vec >= 6'(TRAP_N))
    |-> (trap_req_i & TRAP_MASK) == 8'h00)
    else $error("irq beat trap");
  a_irq_above_level: assert property (
    (arb_hit && arb_vec >= 6'(TRAP_N))
    |-> arb_pri[2:0] > r.sr[SR_IPL +: 3])
    else $error("irq not above level");
  a_shift_range: assert property (
    (sh_amt_i > 6'sd16 || sh_amt_i < -6'sd15) |-> sh_o == 32'h00000000)
    else $error("shift out of range");

  c_exception: cover property (exc_take_o);
  c_trap_taken: cover property (exc_take_o && exc_vec_o < 6'(TRAP_N));
  c_psv_read: cover property (psv_busy_o);
  c_shadow_pop: cover property (push_s_i ##[1:4] pop_s_i);
  c_loop_nest: cover property (loop_start_i ##[1:8] loop_end_i);
endmodule : dcrm_core
`default_nettype wire

// ---- hdl/dcrm_pkg.sv ----
// shared constants and carriers for the core register model
package dcrm_pkg;
  localparam int unsigned PC_W          = 23;
  localparam int unsigned INSN_W        = 24;
  localparam int unsigned WREG_W        = 16;
  localparam int unsigned WREG_N        = 16;
  localparam int unsigned PAGE_W        = 8;
  localparam int unsigned EXC_VEC_N     = 62;
  localparam int unsigned TRAP_N        = 8;
  localparam int unsigned IRQ_N         = 54;
  localparam int unsigned SHR_MAX       = 15;
  localparam int unsigned SHL_MAX       = 16;
  localparam logic [15:0] SP_RESET      = 16'h0800;
  localparam logic [22:0] PC_RESET      = 23'h000000;
  localparam logic [15:0] SR_RESET      = 16'h0000;
  localparam logic [15:0] PSV_WIN_BASE  = 16'h8000;
  localparam logic [15:0] XY_BOUNDARY   = 16'h0C00;
  localparam logic [3:0]  SP_INDEX      = 4'hF;
  localparam logic [3:0]  TRAP_PRI_BASE = 4'h8;
  // status bit positions
  localparam int unsigned SR_C   = 0;
  localparam int unsigned SR_Z   = 1;
  localparam int unsigned SR_OV  = 2;
  localparam int unsigned SR_N   = 3;
  localparam int unsigned SR_RA  = 4;
  localparam int unsigned SR_IPL = 5;
  localparam int unsigned SR_DC  = 8;
  localparam int unsigned SR_DA  = 9;
  localparam logic [15:0] SHADOW_SR_MASK = 16'h010F;

  typedef enum logic [1:0] {
    DCRM_EXEC  = 2'b00,
    DCRM_PSV2  = 2'b01,
    DCRM_EXC   = 2'b10
  } dcrm_state_t;

  typedef struct packed {
    logic        we;
    logic        byte_op;
    logic [3:0]  idx;
    logic [15:0] data;
  } dcrm_wr_t;

  typedef struct packed {
    logic [15:0] start_lo;
    logic [22:0] end_addr;
    logic [15:0] count;
  } dcrm_loop_t;
endpackage : dcrm_pkg

// ---- test/dcrm_prog_mem.sv ----
// program memory model answering each fetch address combinationally
`timescale 1ns/100ps
`default_nettype none
module dcrm_prog_mem (
  // fetch side
  input  wire logic [22:0] addr_i,
  output logic      [23:0] word_o
);
  // address folded into the word so a wrong fetch address shows up
  assign word_o = {addr_i[7:0] ^ 8'h5A, addr_i[15:0]};
endmodule : dcrm_prog_mem
`default_nettype wire

// ---- test/dsp_cpu_core_register_model_tb.sv ----
// self-checking bench for the core register model
`timescale 1ns/100ps
`default_nettype none
module dsp_cpu_core_register_model_tb;
  import dcrm_pkg::*;
  localparam int JMP = 0, CAL = 1, RET = 2, SRW = 3, PSW = 4;
  localparam int PSH = 5, POP = 6, LST = 7, LND = 8, DRD = 9;
  logic         clk_i = 1'b0;
  logic         rst_b_i = 1'b0;
  logic [9:0]   pls;
  logic         stall_i, jump_long_i, bitrev_i, is_y_space_o;
  logic         psv_busy_o, exc_take_o;
  logic [3:0]   rd_idx_i, mul_a_idx_i, mul_b_idx_i;
  logic [22:0]  jump_addr_i, tbl_addr_i, fetch_addr_o, psv_addr_o, a;
  logic [15:0]  ret_word_i, sr_wdata_i, daddr_i, dest_ea_i, sh_src_i, v;
  logic [15:0]  rd_data_o, sr_o, dest_ea_o, psv_data_o, exc_stack_word_o;
  logic [7:0]   psv_wdata_i, psv_page_o, pg, trap_req_i;
  logic [23:0]  insn_i, prefetch_o, tbl_data_o;
  logic [31:0]  mul_o, sh_o;
  logic [31:0]  seed = 32'hB278;
  logic signed [5:0] sh_amt_i;
  logic [53:0]  irq_req_i;
  logic [161:0] irq_pri_i, p;
  logic [5:0]   exc_vec_o;
  logic [63:0]  l1, l2;
  dcrm_wr_t     wr_i;
  dcrm_loop_t   loop_i, loop_o;
  logic [15:0]  sv [4];
  logic [15:0]  ya [4] = '{16'h0BFE, 16'h0C00, 16'h7FFE, 16'h8000};
  int           sa [6] = '{-15, -1, 1, 16, 17, -16};
  int           n_errors = 0;
  int           total_checks = 0;

  always #25 clk_i = ~clk_i;

  dcrm_prog_mem i_pm (.addr_i(fetch_addr_o), .word_o(insn_i));

  dcrm_core i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .insn_i(insn_i),
    .fetch_addr_o(fetch_addr_o), .prefetch_o(prefetch_o), .wr_i(wr_i),
    .rd_idx_i(rd_idx_i), .rd_data_o(rd_data_o),
    .mul_a_idx_i(mul_a_idx_i), .mul_b_idx_i(mul_b_idx_i), .mul_o(mul_o),
    .stall_i(stall_i), .jump_i(pls[JMP]), .jump_long_i(jump_long_i),
    .jump_addr_i(jump_addr_i), .call_i(pls[CAL]), .ret_i(pls[RET]),
    .ret_word_i(ret_word_i), .sr_we_i(pls[SRW]), .sr_wdata_i(sr_wdata_i),
    .psv_we_i(pls[PSW]), .psv_wdata_i(psv_wdata_i), .sr_o(sr_o),
    .psv_page_o(psv_page_o), .push_s_i(pls[PSH]), .pop_s_i(pls[POP]),
    .loop_start_i(pls[LST]), .loop_end_i(pls[LND]), .loop_i(loop_i),
    .loop_o(loop_o), .dread_i(pls[DRD]), .daddr_i(daddr_i),
    .bitrev_i(bitrev_i), .dest_ea_i(dest_ea_i), .dest_ea_o(dest_ea_o),
    .is_y_space_o(is_y_space_o), .psv_busy_o(psv_busy_o),
    .psv_addr_o(psv_addr_o), .psv_data_o(psv_data_o),
    .tbl_addr_i(tbl_addr_i), .tbl_data_o(tbl_data_o), .sh_src_i(sh_src_i),
    .sh_amt_i(sh_amt_i), .sh_o(sh_o), .irq_req_i(irq_req_i),
    .irq_pri_i(irq_pri_i), .trap_req_i(trap_req_i),
    .exc_take_o(exc_take_o), .exc_vec_o(exc_vec_o),
    .exc_stack_word_o(exc_stack_word_o)
  );

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [23:0] pm(input logic [22:0] ad);
    return {ad[7:0] ^ 8'h5A, ad[15:0]};
  endfunction : pm

  // sources kept below bit 15 so sign handling cannot matter
  function automatic logic [31:0] shx(input logic [15:0] s, input int k);
    if (k >= 0 && k <= 16) return {16'h0, s} << k;
    if (k < 0 && k >= -15) return {16'h0, s} >> (-k);
    return 32'h0;
  endfunction : shx

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic idle();
    @(posedge clk_i);
    pls <= '0;
    wr_i.we <= 1'b0;
    @(negedge clk_i);
  endtask : idle

  task automatic go(input int b);
    pls[b] <= 1'b1;
    idle();
  endtask : go

  task automatic wreg(input logic [3:0] i, input logic [15:0] d,
                      input logic b);
    @(posedge clk_i);
    wr_i <= {1'b1, b, i, d};
    idle();
  endtask : wreg

  task automatic rdchk(input logic [3:0] i, input logic [15:0] e);
    @(posedge clk_i);
    rd_idx_i <= i;
    @(negedge clk_i);
    chk(rd_data_o, e, "register read");
  endtask : rdchk

  initial begin
    repeat (4000) @(posedge clk_i);
    n_errors++;
    close_out();
  end

  initial begin
    {pls, stall_i, jump_long_i, bitrev_i, rd_idx_i} = '0;
    {mul_a_idx_i, mul_b_idx_i, jump_addr_i, tbl_addr_i, ret_word_i} = '0;
    {sr_wdata_i, daddr_i, dest_ea_i, sh_src_i, psv_wdata_i} = '0;
    {sh_amt_i, irq_req_i, irq_pri_i, trap_req_i, wr_i, loop_i} = '0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    chk(fetch_addr_o, PC_RESET, "pc reset");
    rdchk(SP_INDEX, SP_RESET);
    for (int i = 0; i < 16; i++) begin
      v = 16'(rnd());
      wreg(4'(i), v, 1'b0);
      rdchk(4'(i), i == 15 ? v & 16'hFFFE : v);
    end
    wreg(4'h4, v, 1'b0);
    wreg(4'h4, 16'hC35A, 1'b1);
    rdchk(4'h4, {v[15:8], 8'h5A});
    sv[0] = 16'(rnd());
    sv[1] = 16'(rnd());
    wreg(4'h6, sv[0], 1'b0);
    wreg(4'h7, sv[1], 1'b0);
    @(posedge clk_i);
    mul_a_idx_i <= 4'h6;
    mul_b_idx_i <= 4'h7;
    @(negedge clk_i);
    chk(mul_o, 32'(sv[0]) * 32'(sv[1]), "product");
    foreach (sa[k]) begin
      v = 16'(rnd()) & 16'h7FFF;
      @(posedge clk_i);
      sh_src_i <= v;
      sh_amt_i <= 6'(sa[k]);
      @(negedge clk_i);
      chk(sh_o, shx(v, sa[k]), "shift");
    end
    @(posedge clk_i);
    jump_addr_i <= 23'h400101;
    go(JMP);
    chk(fetch_addr_o, 23'h000100, "short jump");
    for (int i = 0; i < 3; i++) begin
      a = fetch_addr_o;
      @(negedge clk_i);
      chk(fetch_addr_o, a + 23'h2, "pc step");
      chk(prefetch_o, pm(a), "prefetch");
      chk(tbl_data_o, pm(fetch_addr_o), "table word");
    end
    @(posedge clk_i);
    stall_i <= 1'b1;
    @(negedge clk_i);
    a = fetch_addr_o;
    @(negedge clk_i);
    chk(fetch_addr_o, a, "stall");
    @(posedge clk_i);
    stall_i <= 1'b0;
    jump_long_i <= 1'b1;
    jump_addr_i <= 23'h400100;
    go(JMP);
    chk(fetch_addr_o, 23'h400100, "long jump");
    foreach (ya[k]) begin
      @(posedge clk_i);
      daddr_i <= ya[k];
      @(negedge clk_i);
      chk(is_y_space_o, ya[k] >= XY_BOUNDARY && ya[k] < PSV_WIN_BASE,
          "y space");
    end
    pg = 8'(rnd());
    @(posedge clk_i);
    psv_wdata_i <= pg;
    go(PSW);
    chk(psv_page_o, pg, "page");
    v = {1'b1, 14'(rnd()), 1'b0};
    @(posedge clk_i);
    daddr_i <= v;
    go(DRD);
    chk(psv_busy_o, 1'b1, "window stall");
    chk(psv_addr_o, {pg, v[14:0]}, "window address");
    chk(psv_data_o, pm({pg, v[14:0]}) & 24'h00FFFF, "window data");
    @(negedge clk_i);
    chk(psv_busy_o, 1'b0, "window one cycle");
    @(posedge clk_i);
    dest_ea_i <= v;
    idle();
    chk(dest_ea_o, v, "plain ea");
    @(posedge clk_i);
    bitrev_i <= 1'b1;
    idle();
    sv[0] = {<<{v}};
    chk(dest_ea_o, sv[0], "reversed ea");
    for (int i = 0; i < 4; i++) begin
      sv[i] = 16'(rnd());
      wreg(4'(i), sv[i], 1'b0);
    end
    @(posedge clk_i);
    sr_wdata_i <= 16'hFFFF;
    go(SRW);
    @(posedge clk_i);
    go(PSH);
    for (int i = 0; i < 4; i++) wreg(4'(i), 16'(rnd()), 1'b0);
    @(posedge clk_i);
    sr_wdata_i <= 16'h0000;
    go(SRW);
    @(posedge clk_i);
    go(POP);
    for (int i = 0; i < 4; i++) rdchk(4'(i), sv[i]);
    chk(sr_o, SHADOW_SR_MASK, "shadow flags");
    l1 = {rnd(), rnd()};
    l2 = {rnd(), rnd()};
    @(posedge clk_i);
    loop_i <= l1[54:0];
    go(LST);
    @(posedge clk_i);
    loop_i <= l2[54:0];
    go(LST);
    chk(loop_o, l2[54:0], "loop load");
    @(posedge clk_i);
    go(LND);
    chk(loop_o, l1[54:0], "loop restore");
    @(posedge clk_i);
    jump_long_i <= 1'b0;
    jump_addr_i <= 23'h000100;
    go(JMP);
    wreg(SP_INDEX, 16'h0900, 1'b0);
    @(posedge clk_i);
    sr_wdata_i <= 16'h0060;
    go(SRW);
    p = '0;
    p[15 +: 3] = 3'd3;
    p[27 +: 3] = 3'd3;
    @(posedge clk_i);
    irq_pri_i <= p;
    irq_req_i <= (54'h1 << 5) | (54'h1 << 9);
    @(negedge clk_i);
    @(negedge clk_i);
    chk(exc_take_o, 1'b0, "level not above");
    p[15 +: 3] = 3'd4;
    p[27 +: 3] = 3'd4;
    @(posedge clk_i);
    irq_pri_i <= p;
    @(posedge clk_i);
    irq_req_i <= '0;
    @(negedge clk_i);
    chk(exc_take_o, 1'b1, "irq taken");
    chk(exc_vec_o, 6'd13, "natural order");
    chk(fetch_addr_o, 23'd26, "vector pc");
    chk(exc_stack_word_o, 16'h6000, "stacked word");
    chk(loop_o, l1[54:0], "loop kept");
    rdchk(SP_INDEX, 16'h0904);
    chk(exc_take_o, 1'b0, "one pulse");
    @(posedge clk_i);
    sr_wdata_i <= 16'h0000;
    trap_req_i <= 8'h40;
    go(SRW);
    @(negedge clk_i);
    chk(exc_take_o, 1'b0, "reserved trap");
    @(posedge clk_i);
    trap_req_i <= 8'h44;
    irq_req_i <= 54'h1 << 5;
    @(posedge clk_i);
    trap_req_i <= 8'h00;
    irq_req_i <= '0;
    @(negedge clk_i);
    chk(exc_take_o, 1'b1, "trap taken");
    chk(exc_vec_o < 6'd8, 1'b1, "trap beats irq");
    wreg(SP_INDEX, 16'h0900, 1'b0);
    @(posedge clk_i);
    jump_addr_i <= 23'h000200;
    go(CAL);
    rdchk(SP_INDEX, 16'h0904);
    @(posedge clk_i);
    ret_word_i <= 16'h0301;
    go(RET);
    chk(fetch_addr_o, 23'h000300, "return pc");
    rdchk(SP_INDEX, 16'h0900);
    close_out();
  end
endmodule : dsp_cpu_core_register_model_tb
`default_nettype wire
